// ==== hw/zts_sram_port.sv ====
// Pipelined zero-turnaround synchronous memory port with burst counter
`timescale 1ns/1ps
module zts_sram_port import zts_pkg::*; #(
	parameter bit WIDE_ORG = 1'b1,
	localparam int DW = WIDE_ORG ? WIDE_DATA_W : NARROW_DATA_W,
	localparam int AW = WIDE_ORG ? WIDE_ADDR_W : NARROW_ADDR_W,
	localparam int NB = DW / BYTE_W
) (
	input wire logic core_clk, // Interface clock
	input wire logic rst_b, // Asynchronous reset, active low
	input wire logic [AW-1:0] wordAddress, // External word address
	input wire logic advanceOrLoad, // Low loads, high advances burst
	input wire logic readWrite, // High read, low write
	input wire logic clockGateN, // High suspends the port
	input wire logic chipSelAN, // Select, active low
	input wire logic chipSelB, // Select, active high
	input wire logic chipSelCN, // Select, active low
	input wire logic [NB-1:0] byteWriteN, // Per-byte write enables, low
	input wire logic burstOrderSel, // High interleaved, low linear
	input wire logic outputEnableN, // Asynchronous output enable, low
	input wire logic [DW-1:0] dataLinesIn, // Data bus as seen at the pins
	output logic [DW-1:0] dataLinesOut, // Read data toward the pins
	output logic dataLinesOeN // Low while the port drives the bus
);
	// Only the two documented organisations are served
	if (DW % BYTE_W != 0 || NB < 1) begin : g_bad_org
		$error("data width must be whole 9-bit bytes");
	end

	zts_mem_if #(.DW(DW), .AW(AW), .NB(NB)) mif ();

	// Burst address bits for a given step
	function automatic logic [BURST_BITS-1:0] burstLow(
		input logic [BURST_BITS-1:0] start,
		input logic [BURST_BITS-1:0] count,
		input logic interleaved
	);
		burstLow = interleaved ? (start ^ count) : BURST_BITS'(start + count);
	endfunction

	zts_op_type s1Op_r, s2Op_r, burstOp_r, newOp;
	logic [AW-1:0] s1Addr_r, s2Addr_r, burstBase_r, newAddr;
	logic [NB-1:0] s1ByteN_r, s2ByteN_r;
	logic [BURST_BITS-1:0] burstCnt_r, burstCnt_nxt;
	logic driveRead_r;
	logic selected, loadCmd, advance, run;

	// Three selects must all be active at the edge
	assign selected = ~chipSelAN & chipSelB & ~chipSelCN;
	assign run = ~clockGateN;
	assign loadCmd = ~advanceOrLoad & selected;
	assign advance = advanceOrLoad & (burstOp_r != OP_IDLE);
	assign burstCnt_nxt = BURST_BITS'(burstCnt_r + BURST_STEP);

	// New operation: load, burst step, or nothing; address ignored on advance
	always_comb begin
		newOp = OP_IDLE;
		newAddr = s1Addr_r;
		if (loadCmd) begin
			newOp = readWrite ? OP_READ : OP_WRITE;
			newAddr = wordAddress;
		end else if (advance) begin
			newOp = burstOp_r;
			newAddr = {burstBase_r[AW-1:BURST_BITS],
				burstLow(burstBase_r[BURST_BITS-1:0], burstCnt_nxt, burstOrderSel)};
		end
	end

	// Burst tracking; a deselected load ends any burst in flight
	// An advance with no open burst is a no-op rather than a guess
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			burstOp_r <= OP_IDLE;
			burstBase_r <= '0;
			burstCnt_r <= BURST_START;
		end else if (run) begin
			if (loadCmd) begin
				burstOp_r <= readWrite ? OP_READ : OP_WRITE;
				burstBase_r <= wordAddress;
				burstCnt_r <= BURST_START;
			end else if (!advanceOrLoad) begin
				burstOp_r <= OP_IDLE;
			end else if (advance) begin
				burstCnt_r <= burstCnt_nxt;
			end
		end
	end

	// First stage: command captured at the edge
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			s1Op_r <= OP_IDLE;
			s1Addr_r <= '0;
			s1ByteN_r <= '1;
		end else if (run) begin
			s1Op_r <= newOp;
			s1Addr_r <= newAddr;
			s1ByteN_r <= byteWriteN;
		end
	end

	// Second stage keeps going even after a deselect
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			s2Op_r <= OP_IDLE;
			s2Addr_r <= '0;
			s2ByteN_r <= '1;
			driveRead_r <= 1'b0;
		end else if (run) begin
			s2Op_r <= s1Op_r;
			s2Addr_r <= s1Addr_r;
			s2ByteN_r <= s1ByteN_r;
			driveRead_r <= (s1Op_r == OP_READ);
		end
	end

	// Array access: read one edge after the command, write two edges after
	// Held edges gate the array too, so a frozen write never lands early
	assign mif.hold = clockGateN;
	assign mif.rdEn = (s1Op_r == OP_READ);
	assign mif.rdAddr = s1Addr_r;
	assign mif.wrEn = (s2Op_r == OP_WRITE);
	assign mif.wrAddr = s2Addr_r;
	assign mif.wrData = dataLinesIn;
	assign mif.wrByteEn = ~s2ByteN_r;

	zts_mem_array #(.DW(DW), .AW(AW), .NB(NB)) u_array (
		.core_clk(core_clk),
		.mif(mif)
	);

	// Read register feeds the pins; enable needs no clock
	assign dataLinesOut = mif.rdData;
	assign dataLinesOeN = outputEnableN | ~driveRead_r;

	// Helper qualifiers for the checks below
	logic loadRd, loadWr, deselLoad;
	assign loadRd = run & loadCmd & readWrite;
	assign loadWr = run & loadCmd & ~readWrite;
	assign deselLoad = run & ~advanceOrLoad & ~selected;

	a_read_latency: assert property (@(posedge core_clk) disable iff (!rst_b)
		loadRd ##1 run |=> (driveRead_r && (outputEnableN || !dataLinesOeN)))
		else $error("read data not driven two cycles after command");
	a_write_latency: assert property (@(posedge core_clk) disable iff (!rst_b)
		loadWr ##1 run ##1 run |-> mif.wrEn && mif.wrAddr == $past(wordAddress, 2))
		else $error("write not applied two cycles after command");
	a_oe_async: assert property (@(posedge core_clk) disable iff (!rst_b)
		outputEnableN |-> dataLinesOeN)
		else $error("bus driven while output enable inactive");
	a_gate_freeze: assert property (@(posedge core_clk) disable iff (!rst_b)
		clockGateN |=> $stable(s1Op_r) && $stable(s2Op_r) && $stable(burstCnt_r)
			&& $stable(dataLinesOut))
		else $error("state moved during clock gating");
	a_desel_no_op: assert property (@(posedge core_clk) disable iff (!rst_b)
		deselLoad |=> s1Op_r == OP_IDLE && burstOp_r == OP_IDLE)
		else $error("deselected load started an operation");
	a_desel_release: assert property (@(posedge core_clk) disable iff (!rst_b)
		(deselLoad or loadWr) ##1 run |=> dataLinesOeN)
		else $error("bus not released two cycles after deselect or write");
	a_pending_finish: assert property (@(posedge core_clk) disable iff (!rst_b)
		(run && s1Op_r == OP_WRITE) |=> s2Op_r == OP_WRITE)
		else $error("pending write dropped");
	a_burst_wrap: assert property (@(posedge core_clk) disable iff (!rst_b)
		(run && advance && burstCnt_r == 2'h3) |=> burstCnt_r == 2'h0)
		else $error("burst counter did not wrap");
	a_burst_order: assert property (@(posedge core_clk) disable iff (!rst_b)
		(run && advance && !loadCmd) |=> s1Addr_r[1:0] == ($past(burstOrderSel)
			? ($past(burstBase_r[1:0]) ^ ($past(burstCnt_r) + 2'h1))
			: ($past(burstBase_r[1:0]) + $past(burstCnt_r) + 2'h1)))
		else $error("burst address out of order");

	// Load capture, select qualification, byte enables and release
	a_load_address: assert property (@(posedge core_clk) disable iff (!rst_b)
		(run && loadCmd) |=> s1Addr_r == $past(wordAddress))
		else $error("load did not capture the external address");
	a_burst_restart: assert property (@(posedge core_clk) disable iff (!rst_b)
		(run && loadCmd) |=> burstCnt_r == BURST_START)
		else $error("load did not restart the burst count");
	a_idle_advance: assert property (@(posedge core_clk) disable iff (!rst_b)
		(run && advanceOrLoad && burstOp_r == OP_IDLE) |=> s1Op_r == OP_IDLE)
		else $error("advance with no open burst started an operation");
	a_select_all: assert property (@(posedge core_clk) disable iff (!rst_b)
		(run && !advanceOrLoad && (chipSelAN || !chipSelB || chipSelCN)) |=> s1Op_r == OP_IDLE)
		else $error("load with a select inactive started an operation");
	a_write_bytes: assert property (@(posedge core_clk) disable iff (!rst_b)
		loadWr ##1 run |=> mif.wrByteEn == ~$past(byteWriteN, 2))
		else $error("write byte enables not taken from the load cycle");
	a_read_release: assert property (@(posedge core_clk) disable iff (!rst_b)
		(run && s1Op_r != OP_READ) |=> !driveRead_r)
		else $error("read drive kept without a read in the pipe");

	// Main scenarios worth seeing
	c_read_write: cover property (@(posedge core_clk) disable iff (!rst_b)
		loadRd ##1 loadWr ##1 loadRd);
	c_burst_four: cover property (@(posedge core_clk) disable iff (!rst_b)
		loadRd ##1 (run && advance)[*3]);
	c_stall_read: cover property (@(posedge core_clk) disable iff (!rst_b)
		loadRd ##1 clockGateN ##1 run);
	c_desel_finish: cover property (@(posedge core_clk) disable iff (!rst_b)
		loadRd ##1 deselLoad);
	c_interleaved: cover property (@(posedge core_clk) disable iff (!rst_b)
		run && advance && burstOrderSel);
endmodule

// ==== hw/zts_pkg.sv ====
// Shared constants and types for the zero-turnaround synchronous memory port
package zts_pkg;
	localparam int WIDE_DATA_W = 36;
	localparam int WIDE_ADDR_W = 17;
	localparam int NARROW_DATA_W = 18;
	localparam int NARROW_ADDR_W = 18;
	localparam int BYTE_W = 9;
	localparam int BURST_LEN = 4;
	localparam int BURST_BITS = 2;
	localparam int DATA_LATENCY = 2;
	localparam int CLK_PERIOD_NS = 25;
	localparam logic [BURST_BITS-1:0] BURST_START = 2'h0;
	localparam logic [BURST_BITS-1:0] BURST_STEP = 2'h1;

	// Operation carried down the command-to-data pipeline
	typedef enum logic [1:0] {OP_IDLE, OP_READ, OP_WRITE} zts_op_type;
endpackage

// ==== hw/zts_mem_if.sv ====
// Carrier between the port logic and its storage array
`timescale 1ns/1ps
interface zts_mem_if #(parameter int DW = 36, parameter int AW = 17, parameter int NB = 4);
	logic hold;
	logic rdEn;
	logic [AW-1:0] rdAddr;
	logic [DW-1:0] rdData;
	logic wrEn;
	logic [AW-1:0] wrAddr;
	logic [DW-1:0] wrData;
	logic [NB-1:0] wrByteEn;

	modport ctrl (output hold, rdEn, rdAddr, wrEn, wrAddr, wrData, wrByteEn, input rdData);
	modport mem (input hold, rdEn, rdAddr, wrEn, wrAddr, wrData, wrByteEn, output rdData);
endinterface

// ==== hw/zts_mem_array.sv ====
// Storage array with byte writes and a registered, write-first read port
`timescale 1ns/1ps
module zts_mem_array import zts_pkg::*; #(
	parameter int DW = 36,
	parameter int AW = 17,
	parameter int NB = 4
) (
	input wire logic core_clk, // Array clock
	zts_mem_if.mem mif // Port from the control logic
);
	logic [DW-1:0] store [0:(1<<AW)-1];

	// Byte writes; nothing moves while held
	always_ff @(posedge core_clk) begin
		if (!mif.hold && mif.wrEn) begin
			for (int b = 0; b < NB; b++) begin
				if (mif.wrByteEn[b]) begin
					store[mif.wrAddr][b*BYTE_W +: BYTE_W] <= mif.wrData[b*BYTE_W +: BYTE_W];
				end
			end
		end
	end

	// Write-first forwarding so a read right behind a write sees fresh bytes
	always_ff @(posedge core_clk) begin
		if (!mif.hold && mif.rdEn) begin
			for (int b = 0; b < NB; b++) begin
				if (mif.wrEn && mif.wrByteEn[b] && mif.wrAddr == mif.rdAddr) begin
					mif.rdData[b*BYTE_W +: BYTE_W] <= mif.wrData[b*BYTE_W +: BYTE_W];
				end else begin
					mif.rdData[b*BYTE_W +: BYTE_W] <= store[mif.rdAddr][b*BYTE_W +: BYTE_W];
				end
			end
		end
	end
endmodule

// ==== tb/zts_bus_model.sv ====
// Data bus wire model between the bench's write driver and the port
`timescale 1ns/1ps
module zts_bus_model import zts_pkg::*; (
	input wire logic core_clk, // Bus clock
	input wire logic hostDrv, // Bench drives write data
	input wire logic [WIDE_DATA_W-1:0] hostData, // Write data from the bench
	input wire logic [WIDE_DATA_W-1:0] portData, // Read data from the port
	input wire logic portOeN, // Low while the port drives
	output logic [WIDE_DATA_W-1:0] busLevel // Resolved bus level
);
	logic [WIDE_DATA_W-1:0] last_r = '0;
	// No pull on the bus, so a released bus shows the inverse of its last level
	always_comb begin
		if (!portOeN)
			busLevel = portData;
		else if (hostDrv)
			busLevel = hostData;
		else
			busLevel = ~last_r;
	end
	// Remembered so that stale data never passes for a fresh transfer
	always_ff @(posedge core_clk) begin
		last_r <= busLevel;
	end
endmodule

// ==== tb/tb.sv ====
// Self-checking bench for the zero-turnaround memory port
`timescale 1ns/1ps
module tb;
	import zts_pkg::*;
	logic core_clk = 0, rst_b = 0, ld = 1, rw = 1, gate = 0, sa = 1, sb = 0, sc = 1;
	logic order = 0, oeN = 0, drv = 0, dOeN, oeT = 0;
	logic [16:0] pa = '0, a0, a1;
	logic [3:0] pbe = '1, b0, b1;
	logic [35:0] drvData = '0, dOut, bus, wd;
	logic [35:0] mem [int];
	int bad_count = 0, n_checks = 0, q0 = 0, q1 = 0, salt = 0;
	always #12.5 core_clk = ~core_clk;
	zts_sram_port #(.WIDE_ORG(1'b1)) uut (.core_clk(core_clk), .rst_b(rst_b), .wordAddress(pa),
		.advanceOrLoad(ld), .readWrite(rw), .clockGateN(gate), .chipSelAN(sa), .chipSelB(sb),
		.chipSelCN(sc), .byteWriteN(pbe), .burstOrderSel(order), .outputEnableN(oeN),
		.dataLinesIn(bus), .dataLinesOut(dOut), .dataLinesOeN(dOeN));
	zts_bus_model bm (.core_clk(core_clk), .hostDrv(drv), .hostData(drvData), .portData(dOut),
		.portOeN(dOeN), .busLevel(bus));
	task automatic chk(input string nm, input logic [35:0] e, input logic [35:0] s);
		n_checks++;
		if (s !== e) begin
			bad_count++;
			$display("unexpected %s: expected %h seen %h", nm, e, s);
		end
	endtask
	// One bus cycle: retire the command two ungated edges old, then present a new one
	task automatic step(input int op, input logic [16:0] ea, input logic [3:0] be,
		input logic l, input int s, input logic g);
		@(negedge core_clk);
		gate = g;
		if (g) begin
			// Live-looking write command on a frozen edge must be ignored
			// Bus shows the older pipe entry, frozen as it was
			if (q1 == 1) begin
				chk("held bus", mem[a1], bus);
				chk("held drive", 36'h0, dOeN);
			end else chk("held float", 36'h1, dOeN);
			ld = 0;
			rw = 0;
			pa = ~pa;
			{sa, sb, sc} = 3'h2;
		end else begin
			drv = 0;
			if (q1 == 1) begin
				chk("read bus", mem[a1], bus);
				chk("drive", 36'h0, dOeN);
			end else chk("float", 36'h1, dOeN);
			if (q1 == 2) begin
				salt++;
				wd = {a1 ^ 17'(salt), 2'h2, ~a1};
				drv = 1;
				drvData = wd;
				for (int i = 0; i < 4; i++) if (!b1[i]) mem[a1][i*9+:9] = wd[i*9+:9];
			end
			// Output enable acts with no clock edge at all
			if (oeT && q1 == 1) begin
				#3 oeN = 1;
				#1 chk("async float", 36'h1, dOeN);
				oeN = 0;
			end
			q1 = q0;
			a1 = a0;
			b1 = b0;
			q0 = op;
			a0 = ea;
			b0 = be;
			ld = l;
			rw = (op != 2);
			pa = l ? ~ea : ea;
			pbe = be;
			sa = (s == 1);
			sb = (s != 2);
			sc = (s == 3);
		end
	endtask
	// Four-word burst from base b plus one step that wraps
	task automatic burst(input int op, input logic [16:0] b);
		for (int k = 0; k < 5; k++)
			step(op, {b[16:2], order ? b[1:0] ^ 2'(k) : b[1:0] + 2'(k)}, 4'h0, k != 0, 0, 0);
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Every step is a fixed cycle, so only a runaway simulator needs this
	initial begin
		#200000;
		bad_count++;
		close_out();
	end
	initial begin
		repeat (4) @(negedge core_clk);
		rst_b = 1;
		for (int i = 0; i < 8; i++) step(2, 17'(i), 4'h0, 0, 0, 0);
		// Writes, all but the first partial, each followed at once by a read of the same word
		for (int i = 0; i < 8; i++) step(2 - i % 2, 17'(i / 2), 4'(i * 3), 0, 0, 0);
		step(1, 17'h2, 4'h0, 0, 0, 0);
		for (int s = 1; s < 4; s++) step(0, 17'h5, 4'h0, 0, s, 0);
		step(0, 17'h6, 4'h0, 1, 0, 0);
		// Stalls while a read stands and while another waits in the pipe
		step(1, 17'h3, 4'h0, 0, 0, 0);
		step(0, 17'h0, 4'h0, 1, 0, 1);
		step(1, 17'h4, 4'h0, 0, 0, 0);
		step(0, 17'h0, 4'h0, 1, 0, 1);
		step(0, 17'h0, 4'h0, 1, 0, 1);
		step(0, 17'h0, 4'h0, 0, 1, 0);
		burst(2, 17'h41);
		burst(1, 17'h41);
		repeat (3) step(0, 17'h0, 4'h0, 0, 1, 0);
		// Order select changed only while the port is idle
		order = 1;
		burst(2, 17'h4a);
		burst(1, 17'h4a);
		oeT = 1;
		step(1, 17'h1, 4'h0, 0, 0, 0);
		repeat (2) step(0, 17'h0, 4'h0, 0, 1, 0);
		oeT = 0;
		repeat (3) step(0, 17'h0, 4'h0, 0, 1, 0);
		close_out();
	end
endmodule
